/* core/ics_ctrl_status.sv */
// Control, status, baud generator and state view of the two-wire controller
//
// Decided for this implementation: the AHB-Lite register port.
module ics_ctrl_status (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // AHB-Lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  // Bus line inputs from the pins
  input  wire logic             sdaPin,
  input  wire logic             sclPin,
  // Shift engine
  input  wire ics_pkg::ics_eng_t eng,
  output ics_pkg::ics_cmd_t      cmd,
  // Spare timer
  output logic                  timerIrq
);

  typedef struct packed {
    logic        rdPend;
    logic        wrPend;
    logic [11:0] idx;
    logic        readyOut;
    logic        resp;
    logic [31:0] rdata;
    logic        enable;
    logic        startReq;
    logic        stopReq;
    logic        timerSel;
    logic        txIrqEn;
    logic        nakReq;
    logic        filterEn;
    logic        diagnostic_view;
    logic [7:0]  dataByte;
    logic        dataFull;
    logic        txEmpty;
    logic        arbLost;
    logic        stopRestart;
    logic        notAck;
    logic [15:0] reload;
    logic [15:0] count;
    logic        baudTick;
    logic        timerIrq;
    logic        ackValid;
    logic        ackBit;
    logic        addrPhase;
    logic        dataPhase;
    logic        tenBit;
    logic        restartInd;
    logic        sclDrive;
    logic        busy;
    logic        sdaPrev;
    logic        sclPrev;
    logic        relLines;
    logic [7:0]  stateCode;
    logic        sendStart;
    logic        sendStop;
  } ics_st_t;

  ics_st_t    q;
  ics_st_t    d;
  logic [1:0] lineRaw;
  logic [1:0] lineFilt;
  logic       sdaF;
  logic       sclF;

  assign lineRaw = {sclPin, sdaPin};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : gLine
      ics_line_filter uFilt (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .lineIn   (lineRaw[gi]),
        .filterEn (q.filterEn),
        .lineOut  (lineFilt[gi])
      );
    end
  endgenerate

  assign sdaF = lineFilt[0];
  assign sclF = lineFilt[1];

  logic       addrOk;
  logic [7:0] wb;
  logic [7:0] rd;
  logic [7:0] flags;
  logic       startCond;
  logic       stopCond;
  logic       startSetNow;
  logic       slaveBusy;
  logic       rxBlock;

  always_comb begin
    d           = q;
    d.baudTick  = 1'b0;
    d.timerIrq  = 1'b0;
    d.resp      = 1'b0;
    addrOk      = hsel & htrans[1] & hready;
    wb          = hwdata[7:0];
    startSetNow = 1'b0;
    slaveBusy   = q.enable & eng.slaveAddressed & ~eng.isMaster;
    rxBlock     = slaveBusy & eng.dataPhase & ~eng.txByte;
    startCond   = sclF & q.sclPrev & q.sdaPrev & ~sdaF;
    stopCond    = sclF & q.sclPrev & ~q.sdaPrev & sdaF;

    flags = 8'h00;
    flags[ics_pkg::STV_ACK_VALID] = q.ackValid;
    flags[ics_pkg::STV_ACK]       = q.ackBit;
    flags[ics_pkg::STV_ADDR]      = q.addrPhase;
    flags[ics_pkg::STV_DATA]      = q.dataPhase;
    flags[ics_pkg::STV_TEN_BIT]   = q.tenBit;
    flags[ics_pkg::STV_RESTART]   = q.restartInd;
    flags[ics_pkg::STV_SCL]       = q.sclDrive;
    flags[ics_pkg::STV_BUSY]      = q.busy;

    // Read mux; flush bit always reads as zero
    rd = 8'h00;
    if (q.idx == ics_pkg::IDX_DATA) begin
      rd = q.dataByte;
    end else if (q.idx == ics_pkg::IDX_ISTAT) begin
      rd[ics_pkg::IST_TX_EMPTY]     = q.txEmpty;
      rd[ics_pkg::IST_ARB_LOST]     = q.arbLost;
      rd[ics_pkg::IST_STOP_RESTART] = q.stopRestart;
      rd[ics_pkg::IST_NOT_ACK]      = q.notAck;
    end else if (q.idx == ics_pkg::IDX_CTRL) begin
      rd = {q.enable, q.startReq, q.stopReq, q.timerSel,
            q.txIrqEn, q.nakReq, 1'b0, q.filterEn};
    end else if (q.idx == ics_pkg::IDX_RATE_HI) begin
      rd = q.diagnostic_view ? q.count[15:8] : q.reload[15:8];
    end else if (q.idx == ics_pkg::IDX_RATE_LO) begin
      rd = q.diagnostic_view ? q.count[7:0] : q.reload[7:0];
    end else if (q.idx == ics_pkg::IDX_STATE) begin
      rd = q.diagnostic_view ? q.stateCode : flags;
    end else if (q.idx == ics_pkg::IDX_DIAGNOSTIC_VIEW) begin
      rd = {7'h00, q.diagnostic_view};
    end

    // Reads take one wait state so a write just before is always seen
    if (q.rdPend) begin
      d.rdPend   = 1'b0;
      d.readyOut = 1'b1;
      d.rdata    = {24'h000000, rd};
      if (q.idx == ics_pkg::IDX_ISTAT) begin
        d.arbLost     = 1'b0;
        d.stopRestart = 1'b0;
        if (!eng.isMaster) begin
          d.notAck = 1'b0;
        end
      end
    end

    // Hardware clears of the requests
    if (eng.startSent) begin
      d.startReq = 1'b0;
    end
    if (eng.stopSent) begin
      d.stopReq = 1'b0;
    end
    if (eng.nakSent) begin
      d.nakReq = 1'b0;
    end
    if (q.startReq && slaveBusy) begin
      d.startReq = 1'b0;
    end
    if (q.stopReq && slaveBusy) begin
      d.stopReq = 1'b0;
    end

    // Write data phase
    if (q.wrPend) begin
      d.wrPend = 1'b0;
      if (q.idx == ics_pkg::IDX_CTRL) begin
        d.enable   = wb[ics_pkg::CTL_ENABLE];
        d.timerSel = wb[ics_pkg::CTL_TIMER_SEL];
        d.txIrqEn  = wb[ics_pkg::CTL_TX_IRQ_EN];
        d.filterEn = wb[ics_pkg::CTL_FILTER];
        if (wb[ics_pkg::CTL_START]) begin
          d.startReq  = 1'b1;
          d.notAck    = 1'b0;
          startSetNow = 1'b1;
        end
        if (wb[ics_pkg::CTL_STOP]) begin
          d.stopReq = 1'b1;
          d.notAck  = 1'b0;
        end
        if (wb[ics_pkg::CTL_NAK]) begin
          d.nakReq = 1'b1;
        end
        if (wb[ics_pkg::CTL_FLUSH]) begin
          d.dataFull = 1'b0;
          d.txEmpty  = 1'b1;
        end
      end else if (q.idx == ics_pkg::IDX_DATA) begin
        // Data writes are dropped while an addressed slave is receiving
        if (!rxBlock) begin
          d.dataByte = wb;
          d.dataFull = 1'b1;
          d.txEmpty  = 1'b0;
        end
      end else if (q.idx == ics_pkg::IDX_RATE_HI) begin
        d.reload[15:8] = wb;
      end else if (q.idx == ics_pkg::IDX_RATE_LO) begin
        d.reload[7:0] = wb;
      end else if (q.idx == ics_pkg::IDX_DIAGNOSTIC_VIEW) begin
        d.diagnostic_view = wb[ics_pkg::DIAGNOSTIC_VIEW_BIT];
      end
    end

    // Address phase
    if (addrOk) begin
      d.idx = (haddr[31:14] == 18'h00000) ? haddr[13:2] : ics_pkg::IDX_NONE;
      if (hwrite) begin
        d.wrPend = 1'b1;
      end else begin
        d.rdPend   = 1'b1;
        d.readyOut = 1'b0;
      end
    end

    if (eng.dataTaken) begin
      d.dataFull = 1'b0;
      d.txEmpty  = 1'b1;
    end

    // Bus conditions seen on the filtered lines
    d.sdaPrev = sdaF;
    d.sclPrev = sclF;
    if (startCond) begin
      d.busy = 1'b1;
    end else if (stopCond) begin
      d.busy = 1'b0;
    end

    // Hardware-set flags come last so a set wins over a clear
    if (q.enable && eng.isMaster && eng.sdaSample && eng.sdaDriveHigh && !sdaF) begin
      d.arbLost = 1'b1;
      d.relLines = 1'b1;
    end
    if (q.startReq && slaveBusy) begin
      d.arbLost = 1'b1;
    end
    if (slaveBusy && (stopCond || (startCond && q.busy))) begin
      d.stopRestart = 1'b1;
      d.restartInd  = startCond;
    end
    if (q.enable && eng.isMaster && (eng.nakSent || eng.nakRecv)
        && !q.startReq && !q.stopReq) begin
      d.notAck = 1'b1;
    end
    if (q.enable && !eng.isMaster && eng.txByte && eng.nakRecv) begin
      d.notAck = 1'b1;
    end

    // Acknowledge tracking
    if (eng.byteStart || stopCond || startCond) begin
      d.ackValid = 1'b0;
    end
    if (q.enable && eng.ackDone) begin
      d.ackBit = eng.ackValue;
      if (eng.txByte) begin
        d.ackValid = 1'b1;
      end
      if (eng.addrPhase) begin
        d.tenBit = 1'b0;
      end
    end
    if (startSetNow && eng.isMaster && q.dataByte[7:3] == ics_pkg::TEN_BIT_PREFIX) begin
      d.tenBit = 1'b1;
    end

    d.addrPhase = q.enable & eng.addrPhase;
    d.dataPhase = q.enable & eng.dataPhase;
    d.sclDrive  = q.relLines ? 1'b1 : eng.sclDrive;
    d.stateCode = q.enable ? eng.stateCode : 8'h00;

    // Released lines stay released until the bus goes idle or the enable bit drops
    if (stopCond) begin
      d.relLines = 1'b0;
    end

    // A pending STOP goes out before any START; neither while a byte shifts
    // Next-state release, so a loss seen this cycle already withholds both
    d.sendStop  = q.enable & q.stopReq & eng.isMaster & ~eng.shifting
                & ~d.relLines;
    d.sendStart = q.enable & q.startReq & ~q.stopReq & ~eng.shifting
                & (q.dataFull | eng.shiftFull) & ~slaveBusy & ~d.relLines;

    // Baud counter: counts down to one, then reloads
    if (q.enable || q.timerSel) begin
      if (q.count <= ics_pkg::BAUD_TERM) begin
        d.count = q.reload;
        if (q.enable) begin
          d.baudTick = 1'b1;
        end else begin
          d.timerIrq = 1'b1;
        end
      end else begin
        d.count = q.count - 16'h0001;
      end
    end else begin
      d.count = q.reload;
    end

    // Dropping the enable bit abandons all pending requests
    if (!d.enable) begin
      d.startReq  = 1'b0;
      d.stopReq   = 1'b0;
      d.nakReq    = 1'b0;
      d.sendStart = 1'b0;
      d.sendStop  = 1'b0;
      d.relLines  = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q          <= '0;
      q.readyOut <= 1'b1;
      q.dataByte <= ics_pkg::RST_DATA;
      q.txEmpty  <= 1'b1;
      q.reload   <= {ics_pkg::RST_RATE_HI, ics_pkg::RST_RATE_LO};
      q.count    <= {ics_pkg::RST_RATE_HI, ics_pkg::RST_RATE_LO};
      q.sclDrive <= 1'b1;
      q.sdaPrev  <= 1'b1;
      q.sclPrev  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign hrdata    = q.rdata;
  assign hreadyout = q.readyOut;
  assign hresp     = q.resp;
  assign timerIrq  = q.timerIrq;
  assign cmd       = '{enable:     q.enable,
                       sendStart:  q.sendStart,
                       sendStop:   q.sendStop,
                       sendNak:    q.nakReq,
                       busRelease: q.relLines,
                       txIrqEn:    q.txIrqEn,
                       dataFull:   q.dataFull,
                       baudTick:   q.baudTick,
                       sdaLine:    sdaF,
                       sclLine:    sclF,
                       dataByte:   q.dataByte};

endmodule

/* core/ics_pkg.sv */
// Shared constants and carrier types of the two-wire controller status block
// Behaviour
// - Master drives SDA high, samples low: arbitration lost
// - Addressed slave sees STOP/RESTART: set stop/restart flag
// - Master NAK without pending start/stop sets NAK flag
// - Slave transmit ends on master NAK: flag
// - Start, stop, NAK bits: write-one set only
// - START waits until data or shift holds byte
// - Start during shifting: RESTART after byte, STOP first
// - Start during addressed slave transfer: clear, arbitration lost
// - Stop after current byte; cleared in slave transfer
// - Disabled with timer select: baud counter periodic interrupt
// - NAK request answers next received byte, self-clears
// - Flush empties data register; reads as zero
// - Filter enable: glitch filter, one clock more latency
// - High and low bytes form 16-bit reload
// - Diagnostic view returns live baud counter bytes
// - State register: flags, or state code in diagnostics
// - Ack-valid set after sent byte's acknowledge result
// - Ack bit shows last acknowledge result
// - Address-phase and data-phase status bits follow bus
// - Ten-bit flag on prefix after start, cleared later
// - Restart indicator: zero STOP, one RESTART
// - State shows driven clock level and bus busy
package ics_pkg;

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_DATA    = 12'hf50;
  localparam logic [11:0] IDX_ISTAT   = 12'hf51;
  localparam logic [11:0] IDX_CTRL    = 12'hf52;
  localparam logic [11:0] IDX_RATE_HI = 12'hf53;
  localparam logic [11:0] IDX_RATE_LO = 12'hf54;
  localparam logic [11:0] IDX_STATE   = 12'hf55;
  localparam logic [11:0] IDX_DIAGNOSTIC_VIEW    = 12'hf58;
  localparam logic [11:0] IDX_NONE    = 12'h000;

  // Reset values
  localparam logic [7:0]  RST_RATE_HI = 8'hff;
  localparam logic [7:0]  RST_RATE_LO = 8'hff;
  localparam logic [7:0]  RST_DATA    = 8'h00;

  // Control register fields
  localparam int CTL_ENABLE    = 7;
  localparam int CTL_START     = 6;
  localparam int CTL_STOP      = 5;
  localparam int CTL_TIMER_SEL = 4;
  localparam int CTL_TX_IRQ_EN = 3;
  localparam int CTL_NAK       = 2;
  localparam int CTL_FLUSH     = 1;
  localparam int CTL_FILTER    = 0;

  // Interrupt status fields
  localparam int IST_TX_EMPTY     = 7;
  localparam int IST_ARB_LOST     = 2;
  localparam int IST_STOP_RESTART = 1;
  localparam int IST_NOT_ACK      = 0;

  // State view fields
  localparam int STV_ACK_VALID = 7;
  localparam int STV_ACK       = 6;
  localparam int STV_ADDR      = 5;
  localparam int STV_DATA      = 4;
  localparam int STV_TEN_BIT   = 3;
  localparam int STV_RESTART   = 2;
  localparam int STV_SCL       = 1;
  localparam int STV_BUSY      = 0;

  localparam int DIAGNOSTIC_VIEW_BIT = 0;

  localparam logic [4:0]  TEN_BIT_PREFIX = 5'h1e;
  localparam logic [15:0] BAUD_TERM      = 16'h0001;

  // Status from the shift engine
  typedef struct packed {
    logic       isMaster;
    logic       slaveAddressed;
    logic       shifting;
    logic       shiftFull;
    logic       sdaDriveHigh;
    logic       sdaSample;
    logic       sclDrive;
    logic       addrPhase;
    logic       dataPhase;
    logic       txByte;
    logic       byteStart;
    logic       ackDone;
    logic       ackValue;
    logic       nakSent;
    logic       nakRecv;
    logic       startSent;
    logic       stopSent;
    logic       dataTaken;
    logic [7:0] stateCode;
  } ics_eng_t;

  // Commands and data to the shift engine
  typedef struct packed {
    logic       enable;
    logic       sendStart;
    logic       sendStop;
    logic       sendNak;
    logic       busRelease;
    logic       txIrqEn;
    logic       dataFull;
    logic       baudTick;
    logic       sdaLine;
    logic       sclLine;
    logic [7:0] dataByte;
  } ics_cmd_t;

endpackage

/* core/ics_line_filter.sv */
// Synchroniser and spike filter for one bus line
module ics_line_filter (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Line
  input  wire logic lineIn,
  input  wire logic filterEn,
  output logic      lineOut
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic s4;
    logic out;
  } ics_filt_t;

  ics_filt_t q;
  ics_filt_t d;

  always_comb begin
    d    = q;
    d.s1 = lineIn;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.s4 = q.s3;
    // Filtered path needs one more agreeing stage so a two-clock spike never passes
    if (filterEn) begin
      if (q.s2 == q.s3 && q.s3 == q.s4) begin
        d.out = q.s4;
      end
    end else if (q.s2 == q.s3) begin
      d.out = q.s3;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= '1;
    end else begin
      q <= d;
    end
  end

  assign lineOut = q.out;

endmodule

/* bench/ics_ctrl_status_assertions.sv */
// Concurrent checks on the ports of the control and status block
module ics_ctrl_status_assertions (
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              rst,
  // Bus side
  input wire logic              hsel,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic              hready,
  input wire logic              hreadyout,
  // Line and engine side
  input wire logic              sdaPin,
  input wire ics_pkg::ics_eng_t eng,
  input wire ics_pkg::ics_cmd_t cmd,
  input wire logic              timerIrq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence rdTaken;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence slaveBusy;
    (eng.slaveAddressed && !eng.isMaster) [*3];
  endsequence
  sequence sdaQuiet;
    $stable(sdaPin) [*7];
  endsequence
  rd_wait_a: assert property (rdTaken |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  timer_quiet_a: assert property (
    cmd.enable && $past(cmd.enable) && $past(cmd.enable, 2) |-> !timerIrq)
    else $error("timer event while enabled");
  start_data_a: assert property (cmd.sendStart |-> $past(cmd.dataFull || eng.shiftFull))
    else $error("start issued without a byte");
  start_shift_a: assert property (cmd.sendStart |-> !$past(eng.shifting))
    else $error("start issued during shifting");
  stop_first_a: assert property (cmd.sendStart |-> !cmd.sendStop)
    else $error("start issued while stop pending");
  slave_clear_a: assert property (slaveBusy |-> !cmd.sendStart)
    else $error("start kept during slave transfer");
  nak_hold_a: assert property (
    cmd.sendNak && !eng.nakSent && !eng.slaveAddressed |=> cmd.sendNak || !cmd.enable)
    else $error("nak request dropped early");
  lost_release_a: assert property (cmd.busRelease |-> !cmd.sendStart)
    else $error("start while lines released");
  line_filter_a: assert property (sdaQuiet |-> cmd.sdaLine == sdaPin)
    else $error("filtered line does not follow pin");
endmodule

bind ics_ctrl_status ics_ctrl_status_assertions chk_u (
  .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .sdaPin(sdaPin), .eng(eng), .cmd(cmd),
  .timerIrq(timerIrq));

/* bench/ics_bus_partner.sv */
// Behavioural far side: shift engine answers and other parties on the lines
module ics_bus_partner (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // Bench controls
  input  wire logic [3:0]        lag,
  input  wire logic              pullLow,
  input  wire logic              pullClk,
  input  wire ics_pkg::ics_cmd_t cmd,
  input  wire ics_pkg::ics_eng_t base,
  // Toward the block
  output ics_pkg::ics_eng_t      eng,
  output logic                   sdaPin,
  output logic                   sclPin
);
  logic [3:0] cnt;
  logic       sdaDrv;
  logic       sDone;
  logic       pDone;
  // Open drain with pull-up: another party pulling low always wins
  assign sdaPin = sdaDrv & ~pullLow;
  assign sclPin = ~pullClk;
  always_comb begin
    eng           = base;
    eng.startSent = sDone;
    eng.stopSent  = pDone;
  end
  // Lag of at least one keeps a request from being answered twice
  always_ff @(posedge sys_clk) begin
    sDone <= 1'b0;
    pDone <= 1'b0;
    if (rst) begin
      cnt    <= 4'h0;
      sdaDrv <= 1'b1;
    end else if (!(cmd.sendStart || cmd.sendStop) || sDone || pDone) begin
      cnt <= 4'h0;
    end else if (cnt != lag) begin
      cnt <= cnt + 4'h1;
    end else if (cmd.sendStop) begin
      pDone  <= 1'b1;
      sdaDrv <= 1'b1;
    end else begin
      sDone  <= 1'b1;
      sdaDrv <= 1'b0;
    end
  end
endmodule

/* bench/tb_top.sv */
// Self-checking bench of the two-wire controller status block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic              sys_clk, rst, hsel, hwrite, pullLow, pullClk;
  logic [31:0]       haddr, hwdata, hrdata, rv;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic              hreadyout, hresp, timerIrq, sdaPin, sclPin;
  logic [3:0]        lag;
  ics_pkg::ics_eng_t base, eng;
  ics_pkg::ics_cmd_t cmd;
  int                bad_count, compares;

  ics_ctrl_status DUT (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sdaPin(sdaPin),
    .sclPin(sclPin), .eng(eng), .cmd(cmd), .timerIrq(timerIrq));
  ics_bus_partner peer (.sys_clk(sys_clk), .rst(rst), .lag(lag), .pullLow(pullLow),
    .cmd(cmd), .base(base), .eng(eng), .sdaPin(sdaPin), .sclPin(sclPin), .pullClk(pullClk));

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] ix, input logic [7:0] d);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {18'h0, ix, 2'h0};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  task automatic wr(input logic [11:0] ix, input logic [7:0] d);
    bus(1'b1, ix, d);
  endtask
  task automatic rm(input logic [11:0] ix, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, ix, 8'h00);
    chk(rv[7:0] & m, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Spacing between two pulses of the tick or of the timer event
  task automatic per(input logic tk, input int e);
    int n;
    n = 0;
    while (n < 60 && (tk ? cmd.baudTick : timerIrq) !== 1'b1) begin
      @(posedge sys_clk);
      n++;
    end
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (n < 60 && (tk ? cmd.baudTick : timerIrq) !== 1'b1);
    chk(n[7:0], e[7:0]);
  endtask

  task automatic t_regs;
    rm(ics_pkg::IDX_RATE_HI, 8'hff, 8'hff);
    rm(ics_pkg::IDX_RATE_LO, 8'hff, 8'hff);
    rm(ics_pkg::IDX_ISTAT, 8'hff, 8'h80);
    rm(ics_pkg::IDX_CTRL, 8'hff, 8'h00);
    rm(ics_pkg::IDX_STATE, 8'hff, 8'h02);
    rm(ics_pkg::IDX_NONE, 8'hff, 8'h00);
    chk({7'h0, hresp}, 8'h00);
    $display("regs done");
  endtask
  task automatic t_baud;
    logic [7:0] c0;
    wr(ics_pkg::IDX_RATE_HI, 8'h00);
    wr(ics_pkg::IDX_RATE_LO, 8'h05);
    rm(ics_pkg::IDX_RATE_LO, 8'hff, 8'h05);
    wr(ics_pkg::IDX_CTRL, 8'h10);
    per(1'b0, 5);
    wr(ics_pkg::IDX_CTRL, 8'h90);
    per(1'b1, 5);
    base.stateCode <= 8'hc7;
    wr(ics_pkg::IDX_DIAGNOSTIC_VIEW, 8'h01);
    rm(ics_pkg::IDX_RATE_HI, 8'hff, 8'h00);
    // Two reads four cycles apart must see a moving counter of period five
    bus(1'b0, ics_pkg::IDX_RATE_LO, 8'h00);
    c0 = rv[7:0];
    bus(1'b0, ics_pkg::IDX_RATE_LO, 8'h00);
    chk({7'h0, rv[7:0] != c0 && rv[7:0] <= 8'h05 && rv[7:0] != 8'h00}, 8'h01);
    rm(ics_pkg::IDX_STATE, 8'hff, 8'hc7);
    wr(ics_pkg::IDX_DIAGNOSTIC_VIEW, 8'h00);
    wr(ics_pkg::IDX_CTRL, 8'h00);
    $display("baud done");
  endtask
  task automatic t_flush;
    wr(ics_pkg::IDX_CTRL, 8'h80);
    wr(ics_pkg::IDX_DATA, 8'h5a);
    rm(ics_pkg::IDX_ISTAT, 8'h80, 8'h00);
    wr(ics_pkg::IDX_CTRL, 8'h82);
    rm(ics_pkg::IDX_CTRL, 8'h02, 8'h00);
    rm(ics_pkg::IDX_ISTAT, 8'h80, 8'h80);
    $display("flush done");
  endtask
  task automatic t_start;
    base.isMaster <= 1'b1;
    wr(ics_pkg::IDX_CTRL, 8'hc0);
    cyc(10);
    rm(ics_pkg::IDX_CTRL, 8'h40, 8'h40);
    wr(ics_pkg::IDX_CTRL, 8'h80);
    rm(ics_pkg::IDX_CTRL, 8'h40, 8'h40);
    wr(ics_pkg::IDX_CTRL, 8'h00);
    rm(ics_pkg::IDX_CTRL, 8'h40, 8'h00);
    wr(ics_pkg::IDX_CTRL, 8'h80);
    wr(ics_pkg::IDX_DATA, 8'hf1);
    base.addrPhase <= 1'b1;
    base.txByte    <= 1'b1;
    wr(ics_pkg::IDX_CTRL, 8'hc0);
    rm(ics_pkg::IDX_STATE, 8'h28, 8'h28);
    cyc(12);
    rm(ics_pkg::IDX_CTRL, 8'h40, 8'h00);
    rm(ics_pkg::IDX_STATE, 8'h01, 8'h01);
    base.ackValue <= 1'b1;
    base.ackDone  <= 1'b1;
    @(posedge sys_clk);
    base.ackDone   <= 1'b0;
    base.addrPhase <= 1'b0;
    base.dataPhase <= 1'b1;
    rm(ics_pkg::IDX_STATE, 8'hf8, 8'hd0);
    base.byteStart <= 1'b1;
    @(posedge sys_clk);
    base.byteStart <= 1'b0;
    rm(ics_pkg::IDX_STATE, 8'h80, 8'h00);
    lag <= 4'h9;
    wr(ics_pkg::IDX_CTRL, 8'ha0);
    cyc(16);
    rm(ics_pkg::IDX_CTRL, 8'h20, 8'h00);
    rm(ics_pkg::IDX_STATE, 8'h01, 8'h00);
    $display("start done");
  endtask
  task automatic t_nak;
    base.dataPhase <= 1'b0;
    wr(ics_pkg::IDX_CTRL, 8'h84);
    wr(ics_pkg::IDX_CTRL, 8'h80);
    rm(ics_pkg::IDX_CTRL, 8'h04, 8'h04);
    base.ackValue <= 1'b0;
    base.ackDone  <= 1'b1;
    base.nakSent  <= 1'b1;
    @(posedge sys_clk);
    base.ackDone <= 1'b0;
    base.nakSent <= 1'b0;
    rm(ics_pkg::IDX_CTRL, 8'h04, 8'h00);
    rm(ics_pkg::IDX_STATE, 8'h40, 8'h00);
    rm(ics_pkg::IDX_ISTAT, 8'h01, 8'h01);
    rm(ics_pkg::IDX_ISTAT, 8'h01, 8'h01);
    wr(ics_pkg::IDX_CTRL, 8'ha0);
    rm(ics_pkg::IDX_ISTAT, 8'h01, 8'h00);
    cyc(16);
    $display("nak done");
  endtask
  task automatic t_arb;
    pullLow <= 1'b1;
    cyc(10);
    base.sdaDriveHigh <= 1'b1;
    base.sdaSample    <= 1'b1;
    @(posedge sys_clk);
    base.sdaDriveHigh <= 1'b0;
    base.sdaSample    <= 1'b0;
    cyc(2);
    chk({7'h0, cmd.busRelease}, 8'h01);
    rm(ics_pkg::IDX_ISTAT, 8'h04, 8'h04);
    rm(ics_pkg::IDX_ISTAT, 8'h04, 8'h00);
    pullLow <= 1'b0;
    cyc(10);
    // A two-cycle dip must not reach the filtered line
    wr(ics_pkg::IDX_CTRL, 8'h81);
    pullLow <= 1'b1;
    cyc(2);
    pullLow <= 1'b0;
    cyc(8);
    rm(ics_pkg::IDX_STATE, 8'h01, 8'h00);
    $display("arbitration done");
  endtask
  task automatic t_slave;
    base.isMaster       <= 1'b0;
    base.slaveAddressed <= 1'b1;
    wr(ics_pkg::IDX_DATA, 8'h11);
    wr(ics_pkg::IDX_CTRL, 8'hc0);
    rm(ics_pkg::IDX_CTRL, 8'h40, 8'h00);
    rm(ics_pkg::IDX_ISTAT, 8'h04, 8'h04);
    wr(ics_pkg::IDX_CTRL, 8'ha0);
    rm(ics_pkg::IDX_CTRL, 8'h20, 8'h00);
    base.nakRecv <= 1'b1;
    @(posedge sys_clk);
    base.nakRecv <= 1'b0;
    rm(ics_pkg::IDX_ISTAT, 8'h01, 8'h01);
    rm(ics_pkg::IDX_ISTAT, 8'h01, 8'h00);
    pullLow <= 1'b1;
    cyc(10);
    rm(ics_pkg::IDX_ISTAT, 8'h02, 8'h00);
    pullLow <= 1'b0;
    cyc(10);
    rm(ics_pkg::IDX_ISTAT, 8'h02, 8'h02);
    rm(ics_pkg::IDX_STATE, 8'h04, 8'h00);
    // START, clock low, data high, clock high, then a second START: a RESTART
    pullLow <= 1'b1;
    cyc(8);
    pullClk <= 1'b1;
    cyc(8);
    pullLow <= 1'b0;
    cyc(8);
    pullClk <= 1'b0;
    cyc(8);
    pullLow <= 1'b1;
    cyc(8);
    rm(ics_pkg::IDX_ISTAT, 8'h02, 8'h02);
    rm(ics_pkg::IDX_STATE, 8'h04, 8'h04);
    pullLow <= 1'b0;
    cyc(8);
    $display("slave done");
  endtask

  task automatic results;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    rst       = 1'b1;
    hsel      = 1'b0;
    haddr     = 32'h0;
    htrans    = 2'h0;
    hwrite    = 1'b0;
    hsize     = 3'h2;
    hwdata    = 32'h0;
    base      = '0;
    base.sclDrive = 1'b1;
    pullLow   = 1'b0;
    pullClk   = 1'b0;
    lag       = 4'h2;
    bad_count = 0;
    compares  = 0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs;
    t_baud;
    t_flush;
    t_start;
    t_nak;
    t_arb;
    t_slave;
    results;
  end
  // The tests need about five hundred cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    results;
  end
endmodule
